// ===== test/scm_ctrl_model.sv
// behavioural memory controller driving the sdram command pins
`timescale 1ns/1ps
`default_nettype none
module scm_ctrl_model
  import scm_pkg::*;
#(
  parameter int MODE_LOAD_DELAY = 2,
  parameter int PRECHARGE_TIME  = 3
) (
  // clock
  input  wire logic      mclk,
  // sdram pins
  output wire scm_pins_s pins
);
  scm_pins_s p;
  logic      ckeHold;
  int        holdOff;

  assign pins = p;

  initial begin
    ckeHold = 1'b1;
    holdOff = 0;
    p = '{csN: 1'b0, rasN: 1'b1, casN: 1'b1, weN: 1'b1, cke: 1'b1, default: '0};
  end

  // released lines flip so a stale value is never mistaken for a driven one
  task automatic idle();
    p.csN = 1'b0;
    {p.rasN, p.casN, p.weN} = 3'b111;
    p.cke = ckeHold;
    p.bankSel = ~p.bankSel;
    p.addr = ~p.addr;
    p.dq = ~p.dq;
    {p.byteMaskHigh, p.byteMaskLow} = 2'b00;
  endtask

  task automatic send(input logic [2:0] r, input logic [1:0] b, input logic [11:0] a,
                      input logic [1:0] m, input logic [15:0] d, input logic cs,
                      input logic ck);
    repeat (holdOff) @(posedge mclk);
    holdOff = 0;
    @(posedge mclk);
    #1;
    p.csN = cs;
    {p.rasN, p.casN, p.weN} = r;
    p.cke = ck;
    p.bankSel = b;
    p.addr = a;
    {p.byteMaskHigh, p.byteMaskLow} = m;
    p.dq = d;
    ckeHold = ck;
    @(posedge mclk);
    #1;
    idle();
    if (!cs && r == 3'b000) holdOff = MODE_LOAD_DELAY;
    if (!cs && r == 3'b010) holdOff = PRECHARGE_TIME;
  endtask

  task automatic set_cke(input logic v);
    @(posedge mclk);
    #1;
    ckeHold = v;
    p.cke = v;
  endtask
endmodule
`default_nettype wire

// ===== test/tb_top.sv
// self-checking bench for the sdram command interface
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin testsRun++; if ((got) !== (ex)) begin nErrors++; \
  $display("Error %s expected %h seen %h", nm, ex, got); end end
module tb_top
  import scm_pkg::*;
;
  logic             mclk, resetn;
  wire scm_pins_s   pins;
  logic [15:0]      arrayRdData, dqOut, dqOeN, memWrData, d, k;
  logic             memRdReq, memWr, autoPrecharge, refreshPulse, cmdAccepted;
  logic             selfRefreshActive, deepPowerDown;
  logic [1:0]       memWrByteEn, memBank, tempCompSelfRefresh, driveStrength;
  logic [8:0]       memCol, c;
  logic [11:0]      refreshRow, modeReg, extendedModeReg, r, e;
  logic [3:0]       refreshBankMask, bankOpen;
  logic [2:0]       partialArrayRefresh;
  logic [3:0][11:0] openRow;
  scm_cmd_e         cmdCode, codeM;
  int               nErrors, testsRun, modeM, extM, pwrM, apM, n;
  int               openM[4], rowM[4];
  scm_cmd_e         codeTab[8] = '{CMD_MODE_LOAD, CMD_REFRESH, CMD_PRECHARGE, CMD_ACTIVE,
                                   CMD_WRITE, CMD_READ, CMD_BURST_STOP, CMD_NOP};
  logic [1:0]       tcTab[4] = '{TEMP_COMP_SELF_REFRESH_85, TEMP_COMP_SELF_REFRESH_70, TEMP_COMP_SELF_REFRESH_45, TEMP_COMP_SELF_REFRESH_15};
  logic [2:0]       paTab[5] = '{PARTIAL_ARRAY_REFRESH_FULL, PARTIAL_ARRAY_REFRESH_TWO, PARTIAL_ARRAY_REFRESH_ONE, PARTIAL_ARRAY_REFRESH_HALF, PARTIAL_ARRAY_REFRESH_QUARTER};
  logic [3:0]       bmTab[5] = '{4'hF, 4'h3, 4'h1, 4'h1, 4'h1};
  logic [11:0]      rlTab[5] = '{12'hFFF, 12'hFFF, 12'hFFF, 12'h7FF, 12'h3FF};

  // array answers with a word that names its own bank and column
  assign arrayRdData = {3'h5, memBank, 2'h0, memCol};

  scm_command_interface #(.SREF_BASE_CYCLES(4)) scm_command_interface_inst (
    .mclk, .resetn, .pins, .dqOut, .dqOeN, .arrayRdData, .memRdReq, .memWr, .memWrByteEn,
    .memWrData, .memBank, .memCol, .autoPrecharge, .refreshPulse, .refreshRow,
    .refreshBankMask, .modeReg, .extendedModeReg, .tempCompSelfRefresh, .partialArrayRefresh,
    .driveStrength, .selfRefreshActive, .deepPowerDown, .cmdAccepted, .cmdCode, .bankOpen,
    .openRow);
  scm_ctrl_model scm_ctrl_model_inst (.mclk, .pins);

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  task automatic print_verdict();
    $display("checks %0d errors %0d", testsRun, nErrors);
    if (nErrors == 0 && testsRun > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // issue one command, step the reference state, compare after the decode latency
  task automatic cmd(input logic [2:0] rc, input logic [1:0] b, input logic [11:0] a,
                     input logic [1:0] m = 2'b00, input logic [15:0] dd = 16'h0000,
                     input logic cs = 1'b0, input logic ck = 1'b1);
    bit acc;
    // reserved bank selects on a mode load are taken but load nothing
    acc = !cs && pwrM == 0 && (ck ? rc != 3'b111 : (rc == 3'b001 || rc == 3'b110));
    scm_ctrl_model_inst.send(rc, b, a, m, dd, cs, ck);
    if (acc) begin
      codeM = codeTab[rc];
      case (rc)
        3'b011: begin openM[b] = 1; rowM[b] = a; end
        3'b010: for (int i = 0; i < 4; i++) if (a[10] || i == b) openM[i] = 0;
        3'b000: if (b == 2'b10) extM = a; else if (b == 2'b00) modeM = a;
        3'b001: if (!ck) pwrM = 1;
        3'b110: begin if (!ck) pwrM = 2; if (ck && apM >= 0) openM[apM] = 0; apM = -1; end
        default: ;
      endcase
      if (rc == 3'b100 || rc == 3'b101) apM = a[10] ? b : -1;
    end
    // two sync stages, then one register: the pulse stands in this cycle only
    repeat (2) @(posedge mclk);
    #1;
    `CHK("cmdAccepted", acc, cmdAccepted)
    `CHK("cmdCode", codeM, cmdCode)
    `CHK("modeReg", modeM, modeReg)
    `CHK("extendedModeReg", extM, extendedModeReg)
    `CHK("selfRefreshActive", pwrM == 1, selfRefreshActive)
    `CHK("deepPowerDown", pwrM == 2, deepPowerDown)
    for (int i = 0; i < 4; i++) begin
      `CHK("bankOpen", openM[i], bankOpen[i])
      if (openM[i]) `CHK("openRow", rowM[i], openRow[i])
    end
  endtask

  task automatic wake();
    scm_ctrl_model_inst.set_cke(1'b1);
    repeat (6) @(posedge mclk);
    pwrM = 0;
  endtask

  initial begin
    #200000;
    nErrors++;
    print_verdict();
  end

  initial begin
    void'($urandom(87832));
    resetn = 1'b0;
    modeM = 0; extM = 0; pwrM = 0; apM = -1; codeM = CMD_INHIBIT;
    openM = '{default: 0};
    rowM = '{default: 0};
    repeat (20) @(posedge mclk);
    #1;
    `CHK("dqOeN", 16'hFFFF, dqOeN)
    `CHK("tempCompSelfRefresh", TEMP_COMP_SELF_REFRESH_85, tempCompSelfRefresh)
    `CHK("partialArrayRefresh", PARTIAL_ARRAY_REFRESH_FULL, partialArrayRefresh)
    `CHK("driveStrength", 2'h0, driveStrength)
    resetn = 1'b1;
    r = 12'($urandom);
    cmd(3'b000, 2'b00, r);
    cmd(3'b000, 2'b01, ~r);
    cmd(3'b000, 2'b11, ~r);
    cmd(3'b011, 2'b01, r, 2'b00, 16'h0000, 1'b1);
    cmd(3'b111, 2'b01, r);
    for (int b = 0; b < 4; b++) cmd(3'b011, 2'(b), 12'($urandom));
    cmd(3'b010, 2'b01, 12'h000);
    cmd(3'b010, 2'b10, 12'h400);
    for (int i = 0; i < 5; i++) begin
      e = {5'h00, 2'($urandom), tcTab[i % 4], paTab[i]};
      cmd(3'b000, 2'b10, e);
      `CHK("tempCompSelfRefresh", tcTab[i % 4], tempCompSelfRefresh)
      `CHK("partialArrayRefresh", paTab[i], partialArrayRefresh)
      `CHK("driveStrength", e[6:5], driveStrength)
      cmd(3'b001, 2'($urandom), 12'($urandom), 2'b11, 16'($urandom), 1'b0, 1'b0);
      n = 0;
      repeat (96) begin
        @(posedge mclk);
        #1;
        if (refreshPulse === 1'b1) begin
          n++;
          `CHK("refreshBankMask", bmTab[i], refreshBankMask)
          `CHK("refreshRowInRegion", 1'b1, refreshRow <= rlTab[i])
        end
      end
      `CHK("selfRefreshPace", 1'b1, n >= 96 / (4 << (i % 4)) - 1 && n <= 96 / (4 << (i % 4)) + 1)
      cmd(3'b011, 2'b00, 12'h000, 2'b00, 16'h0000, 1'b0, 1'b0);
      wake();
      cmd(3'b111, 2'b00, 12'h000);
    end
    cmd(3'b011, 2'b11, 12'($urandom));
    for (int m = 0; m < 4; m++) begin
      c = 9'($urandom % 500);
      cmd(3'b101, 2'b11, {1'b0, m == 3, 1'b0, c}, 2'(m));
      `CHK("memRdReq", 1'b1, memRdReq)
      `CHK("memCol", c, memCol)
      `CHK("memBank", 2'b11, memBank)
      `CHK("autoPrecharge", m == 3, autoPrecharge)
      @(posedge mclk);
      #1;
      k = {{8{m[1]}}, {8{m[0]}}};
      `CHK("dqOeN", k, dqOeN)
      `CHK("dqOut", {3'h5, 2'b11, 2'h0, c} & ~k, dqOut & ~k)
      `CHK("memColNext", c + 9'h001, memCol)
      @(posedge mclk);
      #1;
      `CHK("dqOeNOpen", 16'h0000, dqOeN)
      cmd(3'b110, 2'b00, 12'h000);
      `CHK("memRdReqStop", 1'b0, memRdReq)
    end
    cmd(3'b011, 2'b11, 12'($urandom));
    for (int m = 0; m < 4; m++) begin
      d = 16'($urandom);
      c = 9'($urandom);
      cmd(3'b100, 2'b11, {3'h0, c}, 2'(m), d);
      `CHK("memWr", 1'b1, memWr)
      `CHK("memWrData", d, memWrData)
      `CHK("memWrByteEn", ~2'(m), memWrByteEn)
      `CHK("memCol", c, memCol)
      cmd(3'b110, 2'b00, 12'h000);
    end
    cmd(3'b010, 2'b00, 12'h400);
    cmd(3'b001, 2'($urandom), 12'($urandom), 2'b11, 16'($urandom));
    `CHK("refreshPulse", 1'b1, refreshPulse)
    `CHK("refreshBankMaskAuto", 4'hF, refreshBankMask)
    cmd(3'b110, 2'b00, 12'h000, 2'b00, 16'h0000, 1'b0, 1'b0);
    cmd(3'b000, 2'b10, 12'h000, 2'b00, 16'h0000, 1'b0, 1'b0);
    wake();
    cmd(3'b111, 2'b00, 12'h000);
    print_verdict();
  end
endmodule
`default_nettype wire

// ===== verilog/scm_bank.sv
// one bank's open-row tracker
`timescale 1ns/1ps
`default_nettype none
module scm_bank
  import scm_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        resetn,
  // row control
  input  wire logic        activate,
  input  wire logic        close,
  input  wire logic [11:0] row,
  // state
  output logic             isOpen,
  output logic [11:0]      openRow
);

  typedef struct packed {
    logic        isOpen;
    logic [11:0] row;
  } scm_bank_s;

  scm_bank_s s;
  scm_bank_s next_s;

  always_comb begin
    next_s = s;
    if (activate) begin
      next_s.isOpen = 1'b1;
      next_s.row    = row;
    end else if (close) begin
      next_s.isOpen = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign isOpen  = s.isOpen;
  assign openRow = s.row;

endmodule
`default_nettype wire

// ===== verilog/scm_command_interface.sv
// command decode, mode registers, low-power modes and byte masking of a mobile sdram
//
// Contract
// - extended bits 4..3 pick one of four self-refresh temperature rates
// - partial-array field picks refreshed region: four, two, one, half or quarter bank
// - reads and writes reach all banks; only self refresh honours the region
// - extended bits 6..5 pick full, half or quarter output drive
// - unloaded extended register means full array, full drive, 85 degrees
// - chip select high ignores commands; low decodes strobes into eight commands
// - burst-stop code terminates with clock enable high, deep power-down when low
// - refresh code auto refreshes with clock enable high, self refresh when low
// - refresh uses internal row counter and ignores all pins but clock enable
// - mode load writes the twelve address bits into the addressed register
// - both mode registers survive deep power-down entry and exit
// - activate opens given row in given bank until precharged
// - read/write column from low nine bits; bit 10 asks auto precharge
// - read byte mask high floats its lanes two clocks later
// - write byte mask acts with its data: high discards that byte
// - low mask governs data bits 0..7, high mask bits 8..15
// - precharge closes named bank, or all banks when address bit 10 high
// - no-op registers nothing and leaves running operations alone
// - command inhibit deselects; running operations continue
`timescale 1ns/1ps
`default_nettype none
module scm_command_interface
  import scm_pkg::*;
#(
  parameter int SREF_BASE_CYCLES = REFRESH_INTERVAL_CYCLES
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        resetn,
  // sdram pins
  input  wire scm_pins_s   pins,
  output logic [15:0]      dqOut,
  output logic [15:0]      dqOeN,
  // array side
  input  wire logic [15:0] arrayRdData,
  output logic             memRdReq,
  output logic             memWr,
  output logic [1:0]       memWrByteEn,
  output logic [15:0]      memWrData,
  output logic [1:0]       memBank,
  output logic [8:0]       memCol,
  output logic             autoPrecharge,
  // refresh side
  output logic             refreshPulse,
  output logic [11:0]      refreshRow,
  output logic [3:0]       refreshBankMask,
  // configuration and status
  output logic [11:0]      modeReg,
  output logic [11:0]      extendedModeReg,
  output logic [1:0]       tempCompSelfRefresh,
  output logic [2:0]       partialArrayRefresh,
  output logic [1:0]       driveStrength,
  output logic             selfRefreshActive,
  output logic             deepPowerDown,
  output logic             cmdAccepted,
  output scm_cmd_e         cmdCode,
  output logic [3:0]       bankOpen,
  output logic [3:0][11:0] openRow
);

  typedef struct packed {
    scm_pins_s   pinMeta;
    scm_pins_s   pinSync;
    logic [11:0] modeReg;
    logic [11:0] extModeReg;
    scm_pwr_e    powerState;
    logic [15:0] srefCount;
    logic        readActive;
    logic        writeActive;
    logic [1:0]  maskDly1;
    logic [15:0] dqOut;
    logic [15:0] dqOeN;
    logic        memRdReq;
    logic        memWr;
    logic [1:0]  memWrByteEn;
    logic [15:0] memWrData;
    logic [1:0]  memBank;
    logic [8:0]  memCol;
    logic        autoPre;
    logic        refreshPulse;
    logic [11:0] refreshRow;
    logic [3:0]  refreshBankMask;
    logic        cmdAccepted;
    scm_cmd_e    cmdCode;
  } scm_state_s;

  scm_state_s s;
  scm_state_s next_s;
  scm_pins_s  p;
  scm_cmd_e   cmd;
  logic       accept;
  logic [3:0] activateBank;
  logic [3:0] closeBank;
  logic [15:0] srefLimit;

  assign p   = s.pinSync;
  assign cmd = scm_decode(p);
  // longer intervals at cooler settings save self-refresh current
  assign srefLimit = 16'(SREF_BASE_CYCLES << scm_temp_comp_self_refresh_shift(s.extModeReg[4:3])) - 16'h0001;

  always_comb begin
    next_s = s;
    activateBank = 4'h0;
    closeBank    = 4'h0;
    accept       = 1'b0;
    // only the second stage is read by logic
    next_s.pinMeta = pins;
    next_s.pinSync = s.pinMeta;
    next_s.memRdReq     = 1'b0;
    next_s.memWr        = 1'b0;
    next_s.refreshPulse = 1'b0;
    next_s.cmdAccepted  = 1'b0;
    next_s.maskDly1     = {p.byteMaskHigh, p.byteMaskLow};
    next_s.dqOut        = arrayRdData;
    // lanes drive only for a live read beat whose mask came in low
    next_s.dqOeN = ~{{8{s.memRdReq & ~s.maskDly1[1]}},
                     {8{s.memRdReq & ~s.maskDly1[0]}}};
    unique case (s.powerState)
      PWR_SELF_REFRESH: begin
        if (p.cke) begin
          next_s.powerState = PWR_NORMAL;
        end else if (s.srefCount >= srefLimit) begin
          next_s.srefCount       = 16'h0000;
          next_s.refreshPulse    = 1'b1;
          next_s.refreshBankMask = scm_region_banks(s.extModeReg[2:0]);
          // rows outside the region are skipped and lose their data
          next_s.refreshRow = (s.refreshRow + 12'h001) & scm_region_rows(s.extModeReg[2:0]);
        end else begin
          next_s.srefCount = s.srefCount + 16'h0001;
        end
      end
      PWR_DEEP_DOWN: begin
        // mode registers are left untouched here
        if (p.cke) begin
          next_s.powerState = PWR_NORMAL;
        end
      end
      PWR_NORMAL: begin
        // nop and inhibit fall through; bursts keep running
        accept = (cmd != CMD_INHIBIT) && (cmd != CMD_NOP)
                 && (p.cke || cmd == CMD_REFRESH || cmd == CMD_BURST_STOP);
        if (p.cke && s.readActive) begin
          next_s.memRdReq = 1'b1;
          next_s.memCol   = s.memCol + 9'h001;
        end
        if (p.cke && s.writeActive) begin
          next_s.memWr       = 1'b1;
          next_s.memWrData   = p.dq;
          next_s.memWrByteEn = ~{p.byteMaskHigh, p.byteMaskLow};
          next_s.memCol      = s.memCol + 9'h001;
        end
        if (accept) begin
          next_s.cmdAccepted = 1'b1;
          next_s.cmdCode     = cmd;
          unique case (cmd)
            CMD_ACTIVE: begin
              activateBank[p.bankSel] = 1'b1;
            end
            CMD_READ: begin
              // no partial-array gating on normal accesses
              next_s.readActive  = 1'b1;
              next_s.writeActive = 1'b0;
              next_s.memRdReq    = 1'b1;
              next_s.memBank     = p.bankSel;
              next_s.memCol      = p.addr[COL_WIDTH-1:0];
              next_s.autoPre     = p.addr[ADDR_AUTO_PRE];
            end
            CMD_WRITE: begin
              next_s.writeActive = 1'b1;
              next_s.readActive  = 1'b0;
              next_s.memWr       = 1'b1;
              next_s.memWrData   = p.dq;
              next_s.memWrByteEn = ~{p.byteMaskHigh, p.byteMaskLow};
              next_s.memBank     = p.bankSel;
              next_s.memCol      = p.addr[COL_WIDTH-1:0];
              next_s.autoPre     = p.addr[ADDR_AUTO_PRE];
            end
            CMD_BURST_STOP: begin
              next_s.readActive  = 1'b0;
              next_s.writeActive = 1'b0;
              next_s.memRdReq    = 1'b0;
              next_s.memWr       = 1'b0;
              if (p.cke) begin
                // burst length is not tracked, so terminate ends the burst
                if ((s.readActive || s.writeActive) && s.autoPre) begin
                  closeBank[s.memBank] = 1'b1;
                end
              end else begin
                next_s.powerState = PWR_DEEP_DOWN;
              end
            end
            CMD_PRECHARGE: begin
              if (p.addr[ADDR_AUTO_PRE]) begin
                closeBank = 4'hF;
              end else begin
                closeBank[p.bankSel] = 1'b1;
              end
              if (p.addr[ADDR_AUTO_PRE] || p.bankSel == s.memBank) begin
                next_s.readActive  = 1'b0;
                next_s.writeActive = 1'b0;
              end
            end
            CMD_REFRESH: begin
              // row comes from the internal counter; address pins unused
              next_s.readActive  = 1'b0;
              next_s.writeActive = 1'b0;
              if (p.cke) begin
                next_s.refreshPulse    = 1'b1;
                next_s.refreshBankMask = 4'hF;
                next_s.refreshRow      = s.refreshRow + 12'h001;
              end else begin
                next_s.powerState = PWR_SELF_REFRESH;
                next_s.srefCount  = 16'h0000;
              end
            end
            CMD_MODE_LOAD: begin
              if (p.bankSel == BANK_SEL_BASE) begin
                next_s.modeReg = p.addr;
              end else if (p.bankSel == BANK_SEL_EXT) begin
                next_s.extModeReg = p.addr;
              end
            end
            default: begin
            end
          endcase
        end
      end
      default: begin
        next_s.powerState = PWR_NORMAL;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s            <= '0;
      s.modeReg    <= MODE_RESET;
      s.extModeReg <= EXT_MODE_RESET;
      s.powerState <= PWR_NORMAL;
      s.dqOeN      <= 16'hFFFF;
      s.cmdCode    <= CMD_INHIBIT;
    end else begin
      s <= next_s;
    end
  end

  genvar b;
  generate
    for (b = 0; b < 4; b++) begin : gBank
      scm_bank uBank (
        .mclk     (mclk),
        .resetn   (resetn),
        .activate (activateBank[b]),
        .close    (closeBank[b]),
        .row      (p.addr),
        .isOpen   (bankOpen[b]),
        .openRow  (openRow[b])
      );
    end
  endgenerate

  assign dqOut               = s.dqOut;
  assign dqOeN               = s.dqOeN;
  assign memRdReq            = s.memRdReq;
  assign memWr               = s.memWr;
  assign memWrByteEn         = s.memWrByteEn;
  assign memWrData           = s.memWrData;
  assign memBank             = s.memBank;
  assign memCol              = s.memCol;
  assign autoPrecharge       = s.autoPre;
  assign refreshPulse        = s.refreshPulse;
  assign refreshRow          = s.refreshRow;
  assign refreshBankMask     = s.refreshBankMask;
  assign modeReg             = s.modeReg;
  assign extendedModeReg     = s.extModeReg;
  assign tempCompSelfRefresh = s.extModeReg[EXT_TEMP_COMP_SELF_REFRESH_LSB +: 2];
  assign partialArrayRefresh = s.extModeReg[EXT_PARTIAL_ARRAY_REFRESH_LSB +: 3];
  assign driveStrength       = s.extModeReg[EXT_DRIVE_LSB +: 2];
  assign selfRefreshActive   = (s.powerState == PWR_SELF_REFRESH);
  assign deepPowerDown       = (s.powerState == PWR_DEEP_DOWN);
  assign cmdAccepted         = s.cmdAccepted;
  assign cmdCode             = s.cmdCode;

  // checks
  logic extLoaded;
  logic extLoadNow;
  assign extLoadNow = (s.powerState == PWR_NORMAL) && p.cke
                      && cmd == CMD_MODE_LOAD && p.bankSel == BANK_SEL_EXT;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      extLoaded <= 1'b0;
    end else if (extLoadNow) begin
      extLoaded <= 1'b1;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  ext_default_a: assert property (!extLoaded |-> extendedModeReg == EXT_MODE_RESET)
    else $error("extended register left default without a load");
  temp_comp_self_refresh_load_a: assert property (extLoadNow |=> tempCompSelfRefresh == $past(p.addr[4:3]))
    else $error("temperature field not loaded");
  drive_load_a: assert property (extLoadNow |=> driveStrength == $past(p.addr[6:5]))
    else $error("drive field not loaded");
  inhibit_quiet_a: assert property (p.csN |=> !cmdAccepted)
    else $error("command taken while deselected");
  sref_entry_a: assert property ((s.powerState == PWR_NORMAL) && cmd == CMD_REFRESH
                                 && !p.cke |=> selfRefreshActive)
    else $error("self refresh not entered");
  dpd_entry_a: assert property ((s.powerState == PWR_NORMAL) && cmd == CMD_BURST_STOP
                                && !p.cke |=> deepPowerDown)
    else $error("deep power-down not entered");
  dpd_keep_a: assert property (deepPowerDown |=> $stable(modeReg) && $stable(extendedModeReg))
    else $error("mode registers changed in deep power-down");
  read_mask_a: assert property (p.byteMaskLow |-> ##2 dqOeN[7:0] == 8'hFF)
    else $error("masked read lane still driven");
  write_mask_a: assert property (memWr |-> memWrByteEn
                                 == ~$past({p.byteMaskHigh, p.byteMaskLow}))
    else $error("write byte enable does not follow mask");
  pre_all_a: assert property (p.cke && cmd == CMD_PRECHARGE && p.addr[ADDR_AUTO_PRE]
                              && (s.powerState == PWR_NORMAL) |=> bankOpen == 4'h0)
    else $error("precharge all left a bank open");
  sref_region_a: assert property (selfRefreshActive && refreshPulse |->
                                  refreshBankMask == scm_region_banks(partialArrayRefresh))
    else $error("self refresh outside selected region");

  sref_cov: cover property (selfRefreshActive ##1 refreshPulse);
  dpd_cov: cover property (deepPowerDown ##1 !deepPowerDown);
  write_cov: cover property (memWr && memWrByteEn == 2'h1);
  read_cov: cover property (memRdReq ##1 dqOeN == 16'h00FF);

endmodule
`default_nettype wire

// ===== verilog/scm_pkg.sv
// constants, types and decode helpers for the mobile sdram command interface
`default_nettype none
package scm_pkg;

  // clock and self-refresh pacing
  localparam int CLK_PERIOD_NS           = 25;
  localparam int REFRESH_INTERVAL_NS     = 15625;
  localparam int REFRESH_INTERVAL_CYCLES = REFRESH_INTERVAL_NS / CLK_PERIOD_NS;

  // field positions
  localparam int EXT_PARTIAL_ARRAY_REFRESH_LSB  = 0;
  localparam int EXT_TEMP_COMP_SELF_REFRESH_LSB  = 3;
  localparam int EXT_DRIVE_LSB = 5;
  localparam int ADDR_AUTO_PRE = 10;
  localparam int COL_WIDTH     = 9;

  // reset values: full array, full drive, 85 degree setting
  localparam logic [11:0] MODE_RESET     = 12'h000;
  localparam logic [11:0] EXT_MODE_RESET = 12'h000;

  // mode-register selection on the bank-select pins
  localparam logic [1:0] BANK_SEL_BASE = 2'h0;
  localparam logic [1:0] BANK_SEL_EXT  = 2'h2;

  // partial-array codes
  localparam logic [2:0] PARTIAL_ARRAY_REFRESH_FULL    = 3'h0;
  localparam logic [2:0] PARTIAL_ARRAY_REFRESH_TWO     = 3'h1;
  localparam logic [2:0] PARTIAL_ARRAY_REFRESH_ONE     = 3'h2;
  localparam logic [2:0] PARTIAL_ARRAY_REFRESH_HALF    = 3'h5;
  localparam logic [2:0] PARTIAL_ARRAY_REFRESH_QUARTER = 3'h6;

  // temperature codes
  localparam logic [1:0] TEMP_COMP_SELF_REFRESH_85 = 2'h0;
  localparam logic [1:0] TEMP_COMP_SELF_REFRESH_70 = 2'h3;
  localparam logic [1:0] TEMP_COMP_SELF_REFRESH_45 = 2'h2;
  localparam logic [1:0] TEMP_COMP_SELF_REFRESH_15 = 2'h1;

  localparam logic [11:0] ROWS_FULL    = 12'hFFF;
  localparam logic [11:0] ROWS_HALF    = 12'h7FF;
  localparam logic [11:0] ROWS_QUARTER = 12'h3FF;

  typedef enum logic [3:0] {
    CMD_INHIBIT, CMD_NOP, CMD_ACTIVE, CMD_READ, CMD_WRITE,
    CMD_BURST_STOP, CMD_PRECHARGE, CMD_REFRESH, CMD_MODE_LOAD
  } scm_cmd_e;

  typedef enum logic [1:0] {PWR_NORMAL, PWR_SELF_REFRESH, PWR_DEEP_DOWN} scm_pwr_e;

  typedef struct packed {
    logic        csN;
    logic        rasN;
    logic        casN;
    logic        weN;
    logic        cke;
    logic [1:0]  bankSel;
    logic [11:0] addr;
    logic        byteMaskHigh;
    logic        byteMaskLow;
    logic [15:0] dq;
  } scm_pins_s;

  function automatic scm_cmd_e scm_decode(input scm_pins_s p);
    scm_cmd_e c;
    c = CMD_INHIBIT;
    if (!p.csN) begin
      unique case ({p.rasN, p.casN, p.weN})
        3'b111: c = CMD_NOP;
        3'b011: c = CMD_ACTIVE;
        3'b101: c = CMD_READ;
        3'b100: c = CMD_WRITE;
        3'b110: c = CMD_BURST_STOP;
        3'b010: c = CMD_PRECHARGE;
        3'b001: c = CMD_REFRESH;
        3'b000: c = CMD_MODE_LOAD;
      endcase
    end
    return c;
  endfunction

  function automatic logic [3:0] scm_region_banks(input logic [2:0] partial_array_refresh);
    logic [3:0] m;
    m = 4'hF;
    if (partial_array_refresh == PARTIAL_ARRAY_REFRESH_TWO) m = 4'h3;
    if (partial_array_refresh == PARTIAL_ARRAY_REFRESH_ONE || partial_array_refresh == PARTIAL_ARRAY_REFRESH_HALF || partial_array_refresh == PARTIAL_ARRAY_REFRESH_QUARTER) m = 4'h1;
    return m;
  endfunction

  function automatic logic [11:0] scm_region_rows(input logic [2:0] partial_array_refresh);
    logic [11:0] r;
    r = ROWS_FULL;
    if (partial_array_refresh == PARTIAL_ARRAY_REFRESH_HALF) r = ROWS_HALF;
    if (partial_array_refresh == PARTIAL_ARRAY_REFRESH_QUARTER) r = ROWS_QUARTER;
    return r;
  endfunction

  // cooler settings stretch the self-refresh interval
  function automatic logic [1:0] scm_temp_comp_self_refresh_shift(input logic [1:0] temp_comp_self_refresh);
    logic [1:0] s;
    s = 2'h0;
    if (temp_comp_self_refresh == TEMP_COMP_SELF_REFRESH_70) s = 2'h1;
    if (temp_comp_self_refresh == TEMP_COMP_SELF_REFRESH_45) s = 2'h2;
    if (temp_comp_self_refresh == TEMP_COMP_SELF_REFRESH_15) s = 2'h3;
    return s;
  endfunction

endpackage
`default_nettype wire
